// *** test/rtctc_checker.sv ***
// Concurrent assertions on the ports of the trim block.
`timescale 1ns/1ps
module rtctc_checker (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire rtctc_pkg::rtctc_bus_t bus,
  input wire logic                  recall_valid,
  input wire logic                  temp_valid,
  input wire logic                  temp_convert,
  input wire logic                  full_xtal_freq_sel,
  input wire logic signed [6:0]     final_analog_trim,
  input wire logic signed [4:0]     final_digital_trim,
  input wire logic signed [6:0]     fout_analog_trim,
  input wire logic signed [4:0]     fout_digital_trim
);
  // Shadow of the sense enable, an outstanding sample and the age of the last sample.
  logic       tse_q;
  logic       pend_q;
  logic [3:0] age_q;
  logic       ss_wr;
  assign ss_wr = bus.wr_en && bus.addr == 8'h0d;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tse_q  <= 1'b0;
      pend_q <= 1'b0;
      age_q  <= 4'hf;
    end else begin
      tse_q  <= recall_valid ? 1'b0 : (ss_wr ? bus.wdata[7] : tse_q);
      pend_q <= temp_valid ? 1'b0 : (temp_convert ? 1'b1 : pend_q);
      age_q  <= temp_valid ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  AST_FOUT_DT_ZERO: assert property (full_xtal_freq_sel [*2] |-> fout_digital_trim == 5'sh00)
    else $error("digital trim seen at full crystal rate");
  AST_FOUT_DT_PASS: assert property ((!full_xtal_freq_sel && $stable(final_digital_trim)) [*2]
    |-> fout_digital_trim == final_digital_trim) else $error("digital trim missing on output");
  AST_FOUT_AT_PASS: assert property ($stable(final_analog_trim) [*2]
    |-> fout_analog_trim == final_analog_trim) else $error("analog trim missing on output");
  AST_AT_RANGE: assert property (final_analog_trim >= 7'sh61 && final_analog_trim <= 7'sh20)
    else $error("analog trim out of range");
  AST_DT_RANGE: assert property (final_digital_trim >= 5'sh16 && final_digital_trim <= 5'sh0a)
    else $error("digital trim out of range");
  AST_CONV_PULSE: assert property (temp_convert |=> !temp_convert)
    else $error("conversion request longer than one cycle");
  AST_WR_CONV: assert property (ss_wr && bus.wdata[7] && !recall_valid && !pend_q && !temp_convert
    && age_q > 4'h9 |=> temp_convert) else $error("enable write started no conversion");
  AST_OFF_HOLD: assert property (!tse_q [*8] |-> $stable(final_analog_trim) && $stable(final_digital_trim))
    else $error("trims moved while disabled");
  AST_LOAD_AFTER_SAMPLE: assert property ($changed(final_analog_trim) || $changed(final_digital_trim)
    |-> age_q <= 4'h9) else $error("trims moved without a sample");
  COV_CONV: cover property (temp_convert);
  COV_LOAD: cover property ($changed(final_analog_trim));
  COV_FULL: cover property (full_xtal_freq_sel && final_digital_trim != 5'sh00);
endmodule

// *** test/tb_top.sv ***
// Self-checking testbench of the temperature compensation trim block.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("Error %s expected %0d seen %0d", nm, exp, got); end end
module tb_top;
  logic                  clk = 1'b0;
  logic                  reset_n;
  rtctc_pkg::rtctc_bus_t bus;
  logic [7:0]            rdata;
  logic                  recall_valid;
  logic signed [7:0]     turnover;
  logic                  on_battery;
  logic signed [9:0]     temperature;
  logic signed [9:0]     temp_val;
  logic                  temp_valid;
  logic                  temp_convert;
  logic                  fsel;
  logic signed [6:0]     fat;
  logic signed [4:0]     fdt;
  logic signed [6:0]     oat;
  logic signed [4:0]     odt;
  int                    err_total;
  int                    checked;
  int                    conv_cnt;
  logic [7:0]            d;
  rtctc_top #(.SEC_CYCLES(10)) u_rtctc_top (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .recall_valid(recall_valid), .recall_init_trim(8'h05), .recall_curvature(8'h00),
    .recall_step_scale(5'h0f), .turnover(turnover), .on_battery(on_battery), .temperature(temperature),
    .temp_valid(temp_valid), .temp_convert(temp_convert), .full_xtal_freq_sel(fsel),
    .final_analog_trim(fat), .final_digital_trim(fdt), .fout_analog_trim(oat), .fout_digital_trim(odt));
  always #20 clk = ~clk;
  // The bench answers every conversion request one cycle later, like the sensor.
  always @(negedge clk) begin
    temp_valid <= temp_convert;
    temperature <= temp_val;
    conv_cnt <= conv_cnt + int'(temp_convert);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    bus = '{1'b1, 1'b0, a, v};
    @(negedge clk);
    bus = '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    bus = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    bus = '0;
    d = rdata;
  endtask
  task automatic wait_conv(input logic exp_conv);
    int c0;
    c0 = conv_cnt;
    repeat (20) @(negedge clk);
    `CHK("conversion", exp_conv, conv_cnt != c0)
    repeat (10) @(negedge clk);
  endtask
  task automatic window(input int n);
    int c0;
    c0 = conv_cnt;
    repeat (1200) @(negedge clk);
    `CHK("periodic samples", n, conv_cnt - c0)
  endtask
  task automatic t_regs;
    rd(8'h0d);
    `CHK("step scale reset", 8'h10, d)
    @(negedge clk);
    recall_valid = 1'b1;
    @(negedge clk);
    recall_valid = 1'b0;
    rd(8'h0d);
    `CHK("step scale recall", 8'h0f, d)
    rd(8'h0b);
    `CHK("initial trim recall", 8'h05, d)
    wr(8'h0c, 8'h5a);
    rd(8'h0c);
    `CHK("curvature write", 8'h5a, d)
    wr(8'h0c, 8'h00);
    rd(8'h20);
    `CHK("unmapped read", 8'h00, d)
  endtask
  task automatic t_enable;
    wr(8'h0d, 8'h0f);
    wait_conv(1'b0);
    `CHK("analog off", 7'h00, fat)
    rd(8'h0d);
    wr(8'h0d, {3'h4, d[4:0]});
    wait_conv(1'b1);
    `CHK("analog on", 7'h05, fat)
    `CHK("digital on", 5'h00, fdt)
    wr(8'h0b, 8'h3e);
    wr(8'h0d, 8'h8f);
    wait_conv(1'b1);
    `CHK("same sample", 7'h05, fat)
    temp_val = 10'h029;
    wr(8'h0d, 8'h8f);
    wait_conv(1'b1);
    `CHK("new initial trim", 7'h7e, fat)
    wr(8'h0b, 8'h05);
  endtask
  task automatic t_clamp;
    wr(8'h0c, 8'hff);
    temp_val = 10'h03c;
    wr(8'h0d, 8'h8f);
    wait_conv(1'b1);
    `CHK("digital clamp", 5'h0a, fdt)
    `CHK("analog residual", 7'h05, fat)
    fsel = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("full rate digital", 5'h00, odt)
    `CHK("full rate analog", fat, oat)
    fsel = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("divided digital", fdt, odt)
  endtask
  task automatic t_periodic;
    window(2);
    on_battery = 1'b1;
    wr(8'h0d, 8'hcf);
    repeat (50) @(negedge clk);
    window(2);
    wr(8'h0d, 8'haf);
    repeat (50) @(negedge clk);
    window(1);
    wr(8'h0d, 8'hef);
    repeat (50) @(negedge clk);
    window(0);
    on_battery = 1'b0;
    repeat (50) @(negedge clk);
    window(2);
  endtask
  task automatic close_out;
    $display("Checks %0d, errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {reset_n, bus, recall_valid, on_battery, fsel} = '0;
    turnover = 8'h19;
    temp_val = 10'h028;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_enable();
    t_clamp();
    t_periodic();
    close_out();
  end
  // Cuts a hang short well past the longest expected run.
  initial begin
    #2000000;
    err_total++;
    close_out();
  end
endmodule
bind rtctc_top rtctc_checker u_rtctc_checker (.clk(clk), .reset_n(reset_n), .bus(bus),
  .recall_valid(recall_valid), .temp_valid(temp_valid), .temp_convert(temp_convert),
  .full_xtal_freq_sel(full_xtal_freq_sel), .final_analog_trim(final_analog_trim),
  .final_digital_trim(final_digital_trim), .fout_analog_trim(fout_analog_trim),
  .fout_digital_trim(fout_digital_trim));

// *** verilog/rtctc_calc.sv ***
// Compensation calculator: turns one temperature sample into one analog and digital trim pair.
`timescale 1ns/1ps
`include "rtctc_regs.svh"
module rtctc_calc (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 start,
  input  wire logic signed [9:0]    temperature,
  input  wire logic signed [7:0]    turnover,
  input  wire logic [7:0]           curvature,
  input  wire logic [4:0]           step_scale,
  input  wire logic signed [5:0]    initial_trim,
  output logic                      done,
  output rtctc_pkg::rtctc_trim_t    result
);
  typedef struct packed {
    rtctc_pkg::rtctc_state_t state;
    logic signed [10:0]      delta;
    logic [21:0]             square;
    logic signed [15:0]      ppm;
    logic                    done;
    rtctc_pkg::rtctc_trim_t  result;
  } rtctc_calc_st_t;

  rtctc_calc_st_t q;
  rtctc_calc_st_t d;
  logic [29:0]        dev;
  logic signed [15:0] resid;
  logic signed [15:0] dt_full;
  logic signed [15:0] at_full;
  logic signed [21:0] at_scaled;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    // Deviation in 1/256 ppm units: curvature is ppm per degree squared in 1/256 ppm steps.
    dev       = 30'(q.square) * 30'(curvature);
    dt_full   = 16'sd0;
    resid     = 16'sd0;
    at_full   = 16'sd0;
    at_scaled = 22'sd0;
    case (q.state)
      rtctc_pkg::RTCTC_IDLE: begin
        if (start) begin
          d.delta = 11'(temperature) - 11'(turnover);
          d.state = rtctc_pkg::RTCTC_SQUARE;
        end
      end
      rtctc_pkg::RTCTC_SQUARE: begin
        d.square = 22'(q.delta) * 22'(q.delta);
        d.state  = rtctc_pkg::RTCTC_SCALE;
      end
      rtctc_pkg::RTCTC_SCALE: begin
        // Crystal runs slow by the parabola, so the correction is positive; initial trim adds on top.
        d.ppm   = 16'(dev[29:8]) + 16'(initial_trim);
        d.state = rtctc_pkg::RTCTC_LOAD;
      end
      rtctc_pkg::RTCTC_LOAD: begin
        // Coarse pulses of 30.5 ppm take the bulk, the 1 ppm analog trim takes the remainder.
        dt_full = 16'((32'(q.ppm) * 32'sd2) / 32'sd61);
        resid   = 16'(32'(q.ppm) - ((32'(dt_full) * 32'sd61) / 32'sd2));
        // Step scale restores the capacitance step to 1 ppm; 16 is the nominal scale.
        at_scaled = 22'((32'(resid) * 32'sd16) / (32'($signed({1'b0, step_scale})) + 32'sd1));
        at_full   = 16'(at_scaled);
        if (dt_full > 16'(`RTCTC_DT_MAX)) begin
          d.result.digital_trim = `RTCTC_DT_MAX;
        end else if (dt_full < 16'(`RTCTC_DT_MIN)) begin
          d.result.digital_trim = `RTCTC_DT_MIN;
        end else begin
          d.result.digital_trim = 5'(dt_full);
        end
        if (at_full > 16'(`RTCTC_AT_MAX)) begin
          d.result.analog_trim = `RTCTC_AT_MAX;
        end else if (at_full < 16'(`RTCTC_AT_MIN)) begin
          d.result.analog_trim = `RTCTC_AT_MIN;
        end else begin
          d.result.analog_trim = 7'(at_full);
        end
        d.done  = 1'b1;
        d.state = rtctc_pkg::RTCTC_IDLE;
      end
      default: d.state = rtctc_pkg::RTCTC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{state: rtctc_pkg::RTCTC_IDLE, delta: '0, square: '0, ppm: '0, done: 1'b0, result: '0};
    end else begin
      q <= d;
    end
  end

  assign done   = q.done;
  assign result = q.result;
endmodule

// *** verilog/rtctc_pkg.sv ***
// Types shared by the temperature compensation trim block.
package rtctc_pkg;
  typedef enum logic [3:0] {
    RTCTC_IDLE  = 4'b0001,
    RTCTC_SQUARE = 4'b0010,
    RTCTC_SCALE = 4'b0100,
    RTCTC_LOAD  = 4'b1000
  } rtctc_state_t;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } rtctc_bus_t;

  typedef struct packed {
    logic signed [6:0] analog_trim;
    logic signed [4:0] digital_trim;
  } rtctc_trim_t;
endpackage

// *** verilog/rtctc_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the trim block.
`ifndef RTCTC_REGS_SVH
`define RTCTC_REGS_SVH
`define RTCTC_ADDR_INIT_TRIM     8'h0b
`define RTCTC_ADDR_CURVATURE     8'h0c
`define RTCTC_ADDR_STEP_SCALE    8'h0d
`define RTCTC_SS_TSE_BIT         7
`define RTCTC_SS_BAT_HI_BIT      6
`define RTCTC_SS_BAT_LO_BIT      5
`define RTCTC_SS_TRIM_W          5
`define RTCTC_INIT_TRIM_W        6
`define RTCTC_AT_MAX             7'sd32
`define RTCTC_AT_MIN             -7'sd31
`define RTCTC_DT_MAX             5'sd10
`define RTCTC_DT_MIN             -5'sd10
`define RTCTC_SS_NOMINAL         5'h10
`define RTCTC_CLK_HZ             25000000
`define RTCTC_SAMPLE_MAIN_S      60
`define RTCTC_SAMPLE_BAT_MAX_S   600
`define RTCTC_BAT_INT0_S         600
`define RTCTC_BAT_INT1_S         120
`define RTCTC_BAT_INT2_S         60
`endif

// *** verilog/rtctc_top.sv ***
// Temperature compensation trim block with its three calibration registers.
// Operation
// - Each analog trim code step shifts oscillator frequency by one ppm.
// - Analog trim spans plus thirty-two to minus thirty-one ppm.
// - Step scale value rescales analog trim increment for crystal motional capacitance.
// - After calibration each internal analog trim unit equals one ppm.
// - Digital trim adds or drops pulses, 30.5 ppm steps, within 305 ppm.
// - Frequency output shows digital trim except at full crystal frequency.
// - Calculator uses temperature, curvature, turnover, step scale and initial trim.
// - New sample every 60 s on main power, up to 10 minutes on battery.
// - Each calculation result gives exactly one analog and digital trim pair.
// - Compensation stays off until software enables it.
// - Step scale register low five bits hold factory value loaded at power-up.
// - Bit 7 enables temperature sensing and continuous correction on main power.
// - Bits 5 and 6 select compensation behaviour on battery backup.
// - Writing step scale with sense enable set starts a compensation cycle.
// - Modelled deviation is curvature times square of temperature minus turnover.
`timescale 1ns/1ps
`include "rtctc_regs.svh"
module rtctc_top #(
  parameter int unsigned SEC_CYCLES = `RTCTC_CLK_HZ
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire rtctc_pkg::rtctc_bus_t bus,
  output logic [7:0]                rdata,
  input  wire logic                 recall_valid,
  input  wire logic [7:0]           recall_init_trim,
  input  wire logic [7:0]           recall_curvature,
  input  wire logic [4:0]           recall_step_scale,
  input  wire logic signed [7:0]    turnover,
  input  wire logic                 on_battery,
  input  wire logic signed [9:0]    temperature,
  input  wire logic                 temp_valid,
  output logic                      temp_convert,
  input  wire logic                 full_xtal_freq_sel,
  output logic signed [6:0]         final_analog_trim,
  output logic signed [4:0]         final_digital_trim,
  output logic signed [6:0]         fout_analog_trim,
  output logic signed [4:0]         fout_digital_trim
);
  // All registered state lives here; the reset synchroniser sits apart because only the raw reset clears it.
  typedef struct packed {
    logic [7:0]        initial_trim;
    logic [7:0]        curvature;
    logic [7:0]        step_scale;
    logic [7:0]        rdata;
    logic [31:0]       sec_cnt;
    logic [9:0]        sample_cnt;
    logic              convert;
    logic              busy;
    logic              have_last;
    logic signed [9:0] last_temp;
    logic              calc_start;
    logic signed [9:0] calc_temp;
    rtctc_pkg::rtctc_trim_t trim;
  } rtctc_top_st_t;

  rtctc_top_st_t q;
  rtctc_top_st_t d;
  logic [1:0]    rst_sync_q;
  logic          rst_n;
  logic          calc_done;
  logic          temp_sense_enable;
  logic          ss_write;
  logic          sec_tick;
  logic [9:0]    interval;
  rtctc_pkg::rtctc_trim_t calc_result;

  assign rst_n    = rst_sync_q[1];
  assign temp_sense_enable      = q.step_scale[`RTCTC_SS_TSE_BIT];
  assign ss_write = bus.wr_en && (bus.addr == `RTCTC_ADDR_STEP_SCALE);
  // One-second enable pulse from a divider; a small SEC_CYCLES shortens the intervals in simulation.
  assign sec_tick = (q.sec_cnt == 32'(SEC_CYCLES - 1));

  // Battery interval code in bits 6:5; code 3 stops periodic sampling while on battery.
  always_comb begin
    case (q.step_scale[`RTCTC_SS_BAT_HI_BIT:`RTCTC_SS_BAT_LO_BIT])
      2'b00:   interval = 10'(`RTCTC_BAT_INT0_S);
      2'b01:   interval = 10'(`RTCTC_BAT_INT1_S);
      2'b10:   interval = 10'(`RTCTC_BAT_INT2_S);
      default: interval = 10'(`RTCTC_SAMPLE_BAT_MAX_S);
    endcase
    if (!on_battery) begin
      interval = 10'(`RTCTC_SAMPLE_MAIN_S);
    end
  end

  always_comb begin
    d            = q;
    d.convert    = 1'b0;
    d.calc_start = 1'b0;
    d.sec_cnt    = sec_tick ? 32'h0000_0000 : q.sec_cnt + 32'h0000_0001;

    // Recall beats a bus write in the same cycle so the factory values always land.
    if (recall_valid) begin
      d.initial_trim = recall_init_trim;
      d.curvature    = recall_curvature;
      d.step_scale   = {3'h0, recall_step_scale};
    end else if (bus.wr_en) begin
      case (bus.addr)
        `RTCTC_ADDR_INIT_TRIM:  d.initial_trim = bus.wdata;
        `RTCTC_ADDR_CURVATURE:  d.curvature    = bus.wdata;
        `RTCTC_ADDR_STEP_SCALE: d.step_scale   = bus.wdata;
        default: ;
      endcase
    end

    // Read data is registered and stands until the next read.
    if (bus.rd_en) begin
      case (bus.addr)
        `RTCTC_ADDR_INIT_TRIM:  d.rdata = q.initial_trim;
        `RTCTC_ADDR_CURVATURE:  d.rdata = q.curvature;
        `RTCTC_ADDR_STEP_SCALE: d.rdata = q.step_scale;
        default:                d.rdata = 8'h00;
      endcase
    end

    // Periodic sampling only while enabled; battery code 3 stops it on battery.
    if (!temp_sense_enable) begin
      d.sample_cnt = 10'h000;
    end else if (sec_tick) begin
      if (q.sample_cnt + 10'h001 >= interval) begin
        d.sample_cnt = 10'h000;
        if (!(on_battery && q.step_scale[6:5] == 2'b11) && !q.busy) begin
          d.convert = 1'b1;
          d.busy    = 1'b1;
        end
      end else begin
        d.sample_cnt = q.sample_cnt + 10'h001;
      end
    end

    if (ss_write && bus.wdata[`RTCTC_SS_TSE_BIT] && !recall_valid && !q.busy) begin
      d.convert = 1'b1;
      d.busy    = 1'b1;
    end

    if (q.busy && temp_valid) begin
      d.busy      = 1'b0;
      d.have_last = 1'b1;
      d.last_temp = temperature;
      // A sample equal to the previous one leaves the loaded trims alone.
      if (!q.have_last || temperature != q.last_temp) begin
        d.calc_start = 1'b1;
        d.calc_temp  = temperature;
      end
    end

    // A calculation still in flight when sensing is switched off is dropped rather than loaded.
    if (calc_done && temp_sense_enable) begin
      d.trim = calc_result;
    end
  end

  // Reset enters at once but leaves only on a clock edge, so no register sees a runt release.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Every register below is reset by the synchronised reset only; all clear except step scale, which takes its nominal value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.initial_trim <= 8'h00;
      q.curvature    <= 8'h00;
      q.step_scale   <= {3'h0, `RTCTC_SS_NOMINAL};
      q.rdata        <= 8'h00;
      q.sec_cnt      <= 32'h0000_0000;
      q.sample_cnt   <= 10'h000;
      q.convert      <= 1'b0;
      q.busy         <= 1'b0;
      q.have_last    <= 1'b0;
      q.last_temp    <= 10'h000;
      q.calc_start   <= 1'b0;
      q.calc_temp    <= 10'h000;
      q.trim         <= '0;
    end else begin
      q.initial_trim <= d.initial_trim;
      q.curvature    <= d.curvature;
      q.step_scale   <= d.step_scale;
      q.rdata        <= d.rdata;
      q.sec_cnt      <= d.sec_cnt;
      q.sample_cnt   <= d.sample_cnt;
      q.convert      <= d.convert;
      q.busy         <= d.busy;
      q.have_last    <= d.have_last;
      q.last_temp    <= d.last_temp;
      q.calc_start   <= d.calc_start;
      q.calc_temp    <= d.calc_temp;
      q.trim         <= d.trim;
    end
  end

  // The calculator takes only the low six bits of initial trim, as a signed ppm offset.
  rtctc_calc u_calc (
    .clk          (clk),
    .rst_n        (rst_n),
    .start        (q.calc_start),
    .temperature  (q.calc_temp),
    .turnover     (turnover),
    .curvature    (q.curvature),
    .step_scale   (q.step_scale[4:0]),
    .initial_trim (q.initial_trim[5:0]),
    .done         (calc_done),
    .result       (calc_result)
  );

  // The full crystal rate bypasses the pulse add and drop logic, so only the analog trim shows there.
  assign rdata              = q.rdata;
  assign temp_convert       = q.convert;
  assign final_analog_trim  = q.trim.analog_trim;
  assign final_digital_trim = q.trim.digital_trim;
  assign fout_analog_trim   = q.trim.analog_trim;
  assign fout_digital_trim  = full_xtal_freq_sel ? 5'sd0 : q.trim.digital_trim;
endmodule
